// ---- alert_status_defs.svh ----
// constants for the primary alert status register
// Notes on behaviour
// (RULE_01) scan-done bit 15 set when measurement completes
// (RULE_02) scan-done follows scan-complete flag, not writable
// (RULE_03) power-on event bit 14 resets to one
// (RULE_04) power-on event cleared only by writing zero
// (RULE_05) chain host clears power-on after power-up, enumeration
// (RULE_06) serial host clears power-on right after power-up
// (RULE_07) mismatch bit 13 updated each acquisition
// (RULE_08) bit 12 ORs cell overvoltage flags 14:1
// (RULE_09) bit 11 ORs cell undervoltage flags 14:1
// (RULE_10) bit 10 block overvoltage, per block acquisition
// (RULE_11) bit 9 block undervoltage, per block acquisition
// (RULE_12) bit 8 ORs aux cold flags 5:0
// (RULE_13) bit 7 ORs aux hot flags 5:0
// (RULE_14) bit 6 ORs current amp over/under
// (RULE_15) summary bits reflect secondary status registers
// (RULE_16) bit 5 ORs packet-check and crc errors
// (RULE_17) bit 2 ORs enabled balancing alerts
// (RULE_18) bits 1,0 OR failure-mode registers
// (RULE_19) writes to summary bits are ignored
`ifndef ALERT_STATUS_DEFS_SVH
`define ALERT_STATUS_DEFS_SVH
`define PAS_ADDR 8'h02
`define PAS_RESET 16'h4000
`define PAS_BIT_SCAN 15
`define PAS_BIT_POR 14
`define PAS_BIT_MSMTCH 13
`define PAS_BIT_CELL_OV 12
`define PAS_BIT_CELL_UV 11
`define PAS_BIT_BLK_OV 10
`define PAS_BIT_BLK_UV 9
`define PAS_BIT_AUX_OV 8
`define PAS_BIT_AUX_UV 7
`define PAS_BIT_CSA 6
`define PAS_BIT_PEC 5
`define PAS_BIT_INTRFC 4
`define PAS_BIT_CAL 3
`define PAS_BIT_CBAL 2
`define PAS_BIT_FM2 1
`define PAS_BIT_FM1 0
`endif

// ---- alert_status_pkg.sv ----
// types for the primary alert status register
package alert_status_pkg;
  typedef struct packed {
    logic [15:0] status;
  } pas_state_t;
  typedef struct packed {
    logic [13:0] adc_cell_over_flags;
    logic [13:0] comparator_cell_over_flags;
    logic [13:0] adc_cell_under_flags;
    logic [13:0] comparator_cell_under_flags;
    logic [5:0] adc_aux_over_flags;
    logic [5:0] comparator_aux_over_flags;
    logic [5:0] adc_aux_under_flags;
    logic [5:0] comparator_aux_under_flags;
    logic current_amp_over_flag;
    logic current_amp_under_flag;
    logic mismatch_cond;
    logic block_over_cond;
    logic block_under_cond;
  } meas_flags_t;
  typedef struct packed {
    logic up_path_check_error;
    logic down_path_check_error;
    logic serial_crc_error;
    logic [15:0] interface_error_status;
    logic [4:0] calibration_alerts;
    logic [4:0] balancing_alerts;
    logic [4:0] balancing_enable;
    logic [15:0] failure_mode_two;
    logic [15:0] failure_mode_one;
  } side_flags_t;
endpackage

// ---- status_or_reduce.sv ----
// parameterised OR reduction of two flag vectors
`timescale 1ns/1ps
module status_or_reduce #(
  parameter int WIDTH = 14
) (
  input wire logic [WIDTH-1:0] a_i,
  input wire logic [WIDTH-1:0] b_i,
  output logic any_o
);
  if (WIDTH < 1) begin
    $error("width must be at least one");
  end
  assign any_o = |(a_i | b_i);
endmodule

// ---- alert_status_summary.sv ----
// primary alert status register with summary logic
`timescale 1ns/1ps
`include "alert_status_defs.svh"
module alert_status_summary #(
  parameter int CELLS = 14,
  parameter int AUX = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register access from the serial interface logic
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_hit_o,
  // measurement side
  input wire logic scan_complete_flag_i,
  input wire logic acq_done_i,
  input wire logic block_acq_done_i,
  input wire alert_status_pkg::meas_flags_t meas_i,
  // secondary summaries, already level flags
  input wire alert_status_pkg::side_flags_t side_i,
  // register image
  output logic [15:0] primary_alert_status_o
);
  // the flag vectors are fixed by meas_flags_t, so other widths cannot be served
  if (CELLS != 14 || AUX != 6) begin
    $error("flag widths fixed by meas_flags_t");
  end

  alert_status_pkg::pas_state_t state_reg;
  alert_status_pkg::pas_state_t state_next;
  logic cell_ov_any;
  logic cell_uv_any;
  logic aux_ov_any;
  logic aux_uv_any;
  logic por_wr_zero;
  logic amp_any;
  logic pec_any;
  logic bal_any;

  status_or_reduce #(.WIDTH(CELLS)) u_cell_ov (
    .a_i(meas_i.adc_cell_over_flags),
    .b_i(meas_i.comparator_cell_over_flags),
    .any_o(cell_ov_any)
  );
  status_or_reduce #(.WIDTH(CELLS)) u_cell_uv (
    .a_i(meas_i.adc_cell_under_flags),
    .b_i(meas_i.comparator_cell_under_flags),
    .any_o(cell_uv_any)
  );
  status_or_reduce #(.WIDTH(AUX)) u_aux_ov (
    .a_i(meas_i.adc_aux_over_flags),
    .b_i(meas_i.comparator_aux_over_flags),
    .any_o(aux_ov_any)
  );
  status_or_reduce #(.WIDTH(AUX)) u_aux_uv (
    .a_i(meas_i.adc_aux_under_flags),
    .b_i(meas_i.comparator_aux_under_flags),
    .any_o(aux_uv_any)
  );

  // a write with bit 14 at one is no request at all, so only a zero can clear
  assign por_wr_zero = reg_wr_i && (reg_addr_i == `PAS_ADDR) && !reg_wdata_i[`PAS_BIT_POR];
  assign amp_any = meas_i.current_amp_over_flag | meas_i.current_amp_under_flag;
  // crc and both packet-check paths share one bit; interface errors sit elsewhere
  assign pec_any = side_i.up_path_check_error | side_i.down_path_check_error | side_i.serial_crc_error;
  // a balancing alert that is not enabled must not reach the summary
  assign bal_any = |(side_i.balancing_alerts & side_i.balancing_enable);

  always_comb begin
    state_next = state_reg;
    // only bit 14 takes a write; all other bits are source-driven [RULE_19]
    if (por_wr_zero) begin
      state_next.status[`PAS_BIT_POR] = 1'b0; // [RULE_04]
    end
    state_next.status[`PAS_BIT_SCAN] = scan_complete_flag_i; // [RULE_01] [RULE_02]
    // measurement summaries refresh only at acquisition boundaries; in between they hold
    // even if the sources clear, so a read always shows the last finished result
    if (acq_done_i) begin
      state_next.status[`PAS_BIT_MSMTCH] = meas_i.mismatch_cond; // [RULE_07]
      state_next.status[`PAS_BIT_CELL_OV] = cell_ov_any; // [RULE_08]
      state_next.status[`PAS_BIT_CELL_UV] = cell_uv_any; // [RULE_09]
      state_next.status[`PAS_BIT_AUX_OV] = aux_ov_any; // [RULE_12]
      state_next.status[`PAS_BIT_AUX_UV] = aux_uv_any; // [RULE_13]
      state_next.status[`PAS_BIT_CSA] = amp_any; // [RULE_14]
    end
    if (block_acq_done_i) begin
      state_next.status[`PAS_BIT_BLK_OV] = meas_i.block_over_cond; // [RULE_10]
      state_next.status[`PAS_BIT_BLK_UV] = meas_i.block_under_cond; // [RULE_11]
    end
    // secondary summaries track their sources continuously [RULE_15]
    state_next.status[`PAS_BIT_PEC] = pec_any; // [RULE_16]
    state_next.status[`PAS_BIT_INTRFC] = |side_i.interface_error_status;
    state_next.status[`PAS_BIT_CAL] = |side_i.calibration_alerts;
    state_next.status[`PAS_BIT_CBAL] = bal_any; // [RULE_17]
    state_next.status[`PAS_BIT_FM2] = |side_i.failure_mode_two; // [RULE_18]
    state_next.status[`PAS_BIT_FM1] = |side_i.failure_mode_one; // [RULE_18]
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '{status: `PAS_RESET}; // [RULE_03]
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_hit_o = (reg_addr_i == `PAS_ADDR);
  // unmapped addresses read zero so the bus mux can OR answers together
  assign reg_rdata_o = reg_hit_o ? state_reg.status : 16'h0000;
  assign primary_alert_status_o = state_reg.status;

  // when to clear the power-on flag is up to the host; this block only latches it until a zero
  // write lands, so a reset that follows the clear stays visible

  // scan-done is a registered copy of the scan flag, one cycle late, and no write reaches it
  scan_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
    ##1 state_reg.status[`PAS_BIT_SCAN] == $past(scan_complete_flag_i))
    else $error("scan-done does not follow the scan flag");
  scan_sets_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_01]
    $rose(scan_complete_flag_i) |=> state_reg.status[`PAS_BIT_SCAN])
    else $error("scan-done not set after completion");
  scan_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
    $fell(scan_complete_flag_i) |=> !state_reg.status[`PAS_BIT_SCAN])
    else $error("scan-done not cleared with the scan flag");
  scan_nowrite_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
    reg_wr_i && $stable(scan_complete_flag_i) |=> $stable(state_reg.status[`PAS_BIT_SCAN]))
    else $error("a write moved scan-done");

  // power-on flag: one out of reset, cleared by a zero write only
  por_reset_a: assert property (@(posedge clk_i) // [RULE_03]
    $fell(sys_rst_i) |-> state_reg.status[`PAS_BIT_POR])
    else $error("power-on flag not one after reset");
  reset_value_a: assert property (@(posedge clk_i) // [RULE_03]
    $fell(sys_rst_i) |-> state_reg.status == `PAS_RESET)
    else $error("status not at its reset value after reset");
  por_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_04]
    reg_wr_i && reg_addr_i == `PAS_ADDR && !reg_wdata_i[`PAS_BIT_POR] |=> !state_reg.status[`PAS_BIT_POR])
    else $error("power-on flag not cleared by zero write");
  por_one_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_04]
    reg_wr_i && reg_addr_i == `PAS_ADDR && reg_wdata_i[`PAS_BIT_POR] && !state_reg.status[`PAS_BIT_POR]
      |=> !state_reg.status[`PAS_BIT_POR])
    else $error("writing one set the power-on flag");
  por_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_04]
    !(reg_wr_i && reg_addr_i == `PAS_ADDR && !reg_wdata_i[`PAS_BIT_POR])
      |=> state_reg.status[`PAS_BIT_POR] == $past(state_reg.status[`PAS_BIT_POR]))
    else $error("power-on flag changed without zero write");

  // acquisition summaries load on their strobe and hold in between
  mismatch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_07]
    acq_done_i |=> state_reg.status[`PAS_BIT_MSMTCH] == $past(meas_i.mismatch_cond))
    else $error("mismatch alert wrong");
  cell_ov_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_08]
    acq_done_i |=> state_reg.status[`PAS_BIT_CELL_OV]
      == $past(|(meas_i.adc_cell_over_flags | meas_i.comparator_cell_over_flags)))
    else $error("cell overvoltage summary wrong");
  cell_uv_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_09]
    acq_done_i |=> state_reg.status[`PAS_BIT_CELL_UV]
      == $past(|(meas_i.adc_cell_under_flags | meas_i.comparator_cell_under_flags)))
    else $error("cell undervoltage summary wrong");
  aux_cold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_12]
    acq_done_i |=> state_reg.status[`PAS_BIT_AUX_OV]
      == $past(|(meas_i.adc_aux_over_flags | meas_i.comparator_aux_over_flags)))
    else $error("aux cold summary wrong");
  aux_hot_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_13]
    acq_done_i |=> state_reg.status[`PAS_BIT_AUX_UV]
      == $past(|(meas_i.adc_aux_under_flags | meas_i.comparator_aux_under_flags)))
    else $error("aux hot summary wrong");
  amp_sum_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_14]
    acq_done_i |=> state_reg.status[`PAS_BIT_CSA]
      == $past(meas_i.current_amp_over_flag | meas_i.current_amp_under_flag))
    else $error("current amp summary wrong");
  cell_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_07]
    !acq_done_i |=> $stable(state_reg.status[13:6] & 8'he7))
    else $error("acquisition summary changed between acquisitions");
  write_ignore_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_19]
    reg_wr_i && !acq_done_i && !block_acq_done_i |=> $stable(state_reg.status[13:6]))
    else $error("a write changed a measurement summary");

  // block summaries follow the block strobe only
  block_ov_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_10]
    block_acq_done_i |=> state_reg.status[`PAS_BIT_BLK_OV] == $past(meas_i.block_over_cond))
    else $error("block overvoltage bit wrong");
  block_uv_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_11]
    block_acq_done_i |=> state_reg.status[`PAS_BIT_BLK_UV] == $past(meas_i.block_under_cond))
    else $error("block undervoltage bit wrong");
  block_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_10]
    !block_acq_done_i |=> $stable(state_reg.status[10:9]))
    else $error("block summary changed between block acquisitions");

  // secondary summaries are registered copies of their sources
  pec_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_16]
    ##1 state_reg.status[`PAS_BIT_PEC] == $past(side_i.serial_crc_error | side_i.up_path_check_error
      | side_i.down_path_check_error))
    else $error("packet-check summary wrong");
  iface_sum_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_15]
    ##1 state_reg.status[`PAS_BIT_INTRFC] == $past(|side_i.interface_error_status))
    else $error("interface error summary wrong");
  cal_sum_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_15]
    ##1 state_reg.status[`PAS_BIT_CAL] == $past(|side_i.calibration_alerts))
    else $error("calibration summary wrong");
  balance_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_17]
    ##1 state_reg.status[`PAS_BIT_CBAL] == $past(|(side_i.balancing_alerts & side_i.balancing_enable)))
    else $error("balancing summary wrong");
  fm_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_18]
    ##1 state_reg.status[1:0] == {$past(|side_i.failure_mode_two), $past(|side_i.failure_mode_one)})
    else $error("failure-mode summaries wrong");

  // the read port shows the register at its address and zero elsewhere
  read_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    reg_hit_o |-> reg_rdata_o == primary_alert_status_o)
    else $error("read data differs from the register");
  read_other_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !reg_hit_o |-> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");

  cov_por_clear: cover property (@(posedge clk_i) disable iff (sys_rst_i) por_wr_zero);
  cov_scan: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(state_reg.status[`PAS_BIT_SCAN]));
  cov_cell_ov: cover property (@(posedge clk_i) disable iff (sys_rst_i) acq_done_i && cell_ov_any);
  cov_block_uv: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    block_acq_done_i && meas_i.block_under_cond);
  cov_balance: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(state_reg.status[`PAS_BIT_CBAL]));
endmodule

// ---- host_model.sv ----
// host controller model on the register access port
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i,
  input wire logic hit_i
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  task automatic wr(input logic [15:0] d);
    addr_o = 8'h02;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    // released data shows the inverse so a stale word is never read as held
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic h);
    addr_o = a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
    h = hit_i;
  endtask
  // clearing after power-up lets any later reset be seen
  task automatic boot_clear();
    wr(16'hbfff);
  endtask
endmodule

// ---- tb_alert_status_summary.sv ----
// testbench for the primary alert status register
`timescale 1ns/1ps
module tb_alert_status_summary;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scan_i = 1'b0;
  logic acq_i = 1'b0;
  logic blk_i = 1'b0;
  alert_status_pkg::meas_flags_t meas = '0;
  alert_status_pkg::side_flags_t side = '0;
  logic [7:0] addr;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] st;
  logic hit;
  int failures = 0;
  int checks_done = 0;
  logic [15:0] mk [13] = '{16'h1000, 16'h1000, 16'h0800, 16'h0800, 16'h0100, 16'h0100, 16'h0080,
    16'h0080, 16'h0040, 16'h0040, 16'h2000, 16'h0400, 16'h0200};
  logic [15:0] sk [9] = '{16'h0020, 16'h0020, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0000,
    16'h0002, 16'h0001};
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  alert_status_summary i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit), .scan_complete_flag_i(scan_i),
    .acq_done_i(acq_i), .block_acq_done_i(blk_i), .meas_i(meas), .side_i(side), .primary_alert_status_o(st));
  host_model i_host (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rdata_i(rdata), .hit_i(hit));
  task automatic cyc();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [15:0] e);
    logic [15:0] d;
    logic h;
    i_host.rd(8'h02, d, h);
    chk("status", e, d);
    chk("hit", 16'h0001, {15'h0000, h});
    chk("image", e, st);
  endtask
  task automatic pulse(input logic b);
    blk_i = b;
    acq_i = ~b;
    cyc();
    blk_i = 1'b0;
    acq_i = 1'b0;
  endtask
  task automatic t_reset();
    logic [15:0] d;
    logic h;
    sys_rst_i = 1'b1;
    repeat (2) cyc();
    sys_rst_i = 1'b0;
    rchk(16'h4000);
    i_host.rd(8'h07, d, h);
    chk("unmapped", 16'h0000, d);
    chk("hit", 16'h0000, {15'h0000, h});
    $display("t_reset done");
  endtask
  task automatic t_por();
    i_host.wr(16'hffff);
    rchk(16'h4000);
    i_host.boot_clear();
    rchk(16'h0000);
    i_host.wr(16'h4000);
    rchk(16'h0000);
    $display("t_por done");
  endtask
  task automatic t_scan();
    scan_i = 1'b1;
    cyc();
    rchk(16'h8000);
    i_host.wr(16'h0000);
    rchk(16'h8000);
    scan_i = 1'b0;
    cyc();
    rchk(16'h0000);
    $display("t_scan done");
  endtask
  // the wrong strobe must neither load nor clear the bit
  task automatic t_meas(input int k, input logic b);
    meas = '0;
    case (k)
      0: meas.adc_cell_over_flags[13] = 1'b1;
      1: meas.comparator_cell_over_flags[0] = 1'b1;
      2: meas.adc_cell_under_flags[0] = 1'b1;
      3: meas.comparator_cell_under_flags[13] = 1'b1;
      4: meas.adc_aux_over_flags[5] = 1'b1;
      5: meas.comparator_aux_over_flags[0] = 1'b1;
      6: meas.adc_aux_under_flags[0] = 1'b1;
      7: meas.comparator_aux_under_flags[5] = 1'b1;
      8: meas.current_amp_over_flag = 1'b1;
      9: meas.current_amp_under_flag = 1'b1;
      10: meas.mismatch_cond = 1'b1;
      11: meas.block_over_cond = 1'b1;
      default: meas.block_under_cond = 1'b1;
    endcase
    cyc();
    rchk(16'h0000);
    pulse(~b);
    rchk(16'h0000);
    pulse(b);
    rchk(mk[k]);
    meas = '0;
    pulse(~b);
    rchk(mk[k]);
    i_host.wr(16'h0000);
    rchk(mk[k]);
    pulse(b);
    rchk(16'h0000);
  endtask
  task automatic t_side(input int k);
    case (k)
      0: side.up_path_check_error = 1'b1;
      1: side.down_path_check_error = 1'b1;
      2: side.serial_crc_error = 1'b1;
      3: side.interface_error_status[15] = 1'b1;
      4: side.calibration_alerts[4] = 1'b1;
      5: side = {1'b0, 1'b0, 1'b0, 16'h0000, 5'h00, 5'h01, 5'h01, 16'h0000, 16'h0000};
      6: side.balancing_alerts[1] = 1'b1;
      7: side.failure_mode_two[15] = 1'b1;
      default: side.failure_mode_one[0] = 1'b1;
    endcase
    cyc();
    rchk(sk[k]);
    side = '0;
    cyc();
    rchk(16'h0000);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_por();
    t_scan();
    for (int k = 0; k < 13; k++) t_meas(k, k > 10);
    $display("t_meas done");
    for (int k = 0; k < 9; k++) t_side(k);
    $display("t_side done");
    t_reset();
    end_sim();
  end
  initial begin
    #20000;
    failures++;
    $display("Error watchdog expected end seen hang");
    end_sim();
  end
endmodule
